// File: common/cmd_port_pkg.sv
// Shared constants and carrier types of the host serial command port
`default_nettype none
package cmd_port_pkg;
  localparam int BYTE_WIDTH      = 8;
  localparam int BIT_COUNT_WIDTH = 3;
  localparam int SYNC_STAGES     = 3;
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic [7:0] RESET_REPLY  = 8'h00;
  localparam logic [2:0] BIT_LAST     = 3'h7;
  localparam logic [2:0] BIT_FIRST    = 3'h0;
  localparam logic [1:0] RESET_COUNT  = 2'h0;

  // One received byte with its position in the command
  typedef struct packed {
    logic [7:0] data;
    logic       first;
  } rx_byte_type;

  // Command as handed to the system side
  typedef struct packed {
    logic [7:0] byte0;
    logic [7:0] byte1;
    logic       two_bytes;
  } command_type;
endpackage
`default_nettype wire

// File: logic/host_serial_command_port.sv
// Top of the host serial command port, device side
//
// Overview of operation
// [R01] Commands arrive as one or two bytes, each bit 7 first, and are assembled in that order.
// [R02] Reply bytes leave on the reply line bit 7 first down to bit 0.
// [R03] Each command data bit is sampled on the rising serial clock edge.
// [R04] A command executes after its last rising clock edge, once the chip select rise has passed the synchroniser.
// [R05] The port works with a serial clock idling either low or high.
// [R06] The reply line is driven only while chip select is low and released after; the enable follows synchronised select, four system clock edges late.
`default_nettype none
module host_serial_command_port
  import cmd_port_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              resetn_i,
  input  wire logic              serial_clk_i,
  input  wire logic              chip_select_n_i,
  input  wire logic              command_data_in_i,
  output logic                   reply_data_o,
  output logic                   reply_data_oe_o,
  input  wire logic [7:0]        reply_byte_i,
  output var cmd_port_pkg::command_type command_o,
  output logic                   command_valid_o,
  output logic                   frame_active_o
);
  import cmd_port_pkg::*;

  logic [7:0] link_byte;
  logic       link_toggle;
  logic       link_reply_bit;
  logic [2:0] sync_out;
  logic [2:0] sync_stable;
  logic       toggle_seen;
  logic       cs_low;
  logic [1:0] byte_count;
  logic [7:0] first_byte;
  logic [7:0] second_byte;
  logic       oe_q;
  logic       reply_q;

  serial_shifter u_shifter (
    .serial_clk_i      (serial_clk_i),
    .resetn_i          (resetn_i),
    .chip_select_n_i   (chip_select_n_i),
    .command_data_in_i (command_data_in_i),
    .reply_byte_i      (reply_byte_i),
    .rx_byte_o         (link_byte),
    .rx_toggle_o       (link_toggle),
    .reply_bit_o       (link_reply_bit)
  );

  level_sync #(.WIDTH(3)) u_sync (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .async_i   ({link_toggle, ~chip_select_n_i, link_reply_bit}),
    .sync_o    (sync_out),
    .stable_o  (sync_stable)
  );

  // Byte is stable long before its toggle settles through three stages
  wire toggle_now = sync_out[2];
  wire byte_event = sync_stable[2] && (toggle_now != toggle_seen);
  wire cs_now     = sync_stable[1] ? sync_out[1] : cs_low;
  wire cs_rise    = cs_low && !cs_now;
  wire cs_fall    = !cs_low && cs_now;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      toggle_seen <= 1'b0;
      cs_low      <= 1'b0;
    end else begin
      toggle_seen <= sync_stable[2] ? toggle_now : toggle_seen;
      cs_low      <= cs_now;
    end
  end

  // [R01] bytes kept in order
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      byte_count  <= RESET_COUNT;
      first_byte  <= RESET_BYTE;
      second_byte <= RESET_BYTE;
    end else if (byte_event && byte_count == 2'h0) begin
      first_byte <= link_byte;
      byte_count <= 2'h1;
    end else if (byte_event && byte_count == 2'h1) begin
      second_byte <= link_byte;
      byte_count  <= 2'h2;
    end else if (cs_fall) begin
      byte_count <= RESET_COUNT;
    end
  end

  // [R04] execute at frame end
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      command_o       <= '0;
      command_valid_o <= 1'b0;
    end else begin
      command_valid_o <= cs_rise && (byte_count != 2'h0);
      // Frame without a full byte leaves the last command untouched
      if (cs_rise && (byte_count != 2'h0)) begin
        command_o.byte0     <= first_byte;
        command_o.byte1     <= second_byte;
        command_o.two_bytes <= (byte_count == 2'h2);
      end
    end
  end

  // [R06] drive from the synchronised select, four system clock edges behind chip select
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      oe_q    <= 1'b0;
      reply_q <= 1'b0;
    end else begin
      oe_q    <= cs_now;
      reply_q <= sync_out[0];
    end
  end

  assign reply_data_oe_o = oe_q;
  assign reply_data_o    = reply_q;
  assign frame_active_o  = cs_low;
endmodule
`default_nettype wire

// File: logic/level_sync.sv
// Three-stage synchroniser for a level crossing into the system clock
`default_nettype none
module level_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o,
  output logic      [WIDTH-1:0] stable_o
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  initial begin
    if (WIDTH < 1) $error("level_sync width must be positive");
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta <= '0;
      s2   <= '0;
      s3   <= '0;
    end else begin
      meta <= async_i;
      s2   <= meta;
      s3   <= s2;
    end
  end

  assign sync_o   = s3;
  // A change counts only once stages two and three agree
  assign stable_o = ~(s2 ^ s3);
endmodule
`default_nettype wire

// File: logic/serial_shifter.sv
// Link-clock shift logic: command bytes in on rising, reply bits out on falling
`default_nettype none
module serial_shifter
  import cmd_port_pkg::*;
(
  input  wire logic       serial_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       chip_select_n_i,
  input  wire logic       command_data_in_i,
  input  wire logic [7:0] reply_byte_i,
  output logic      [7:0] rx_byte_o,
  output logic            rx_toggle_o,
  output logic            reply_bit_o
);
  logic [2:0] bit_count;
  logic [6:0] shift_in;
  logic [7:0] shift_out;
  logic [2:0] out_count;
  logic       rose_seen;
  wire  [7:0] next_byte = {shift_in, command_data_in_i};

  // Chip select high clears the frame, so an idle-high clock adds no bits.
  // [R03] sample on rising
  always_ff @(posedge serial_clk_i or posedge chip_select_n_i) begin
    if (chip_select_n_i) begin
      bit_count <= BIT_FIRST;
      shift_in  <= '0;
      rose_seen <= 1'b0;
    end else begin
      // [R01] msb first assembly
      shift_in  <= next_byte[6:0];
      bit_count <= bit_count + 3'h1;
      rose_seen <= 1'b1;
    end
  end

  // Byte and toggle survive deselect so the system side sees the last byte
  always_ff @(posedge serial_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_byte_o   <= RESET_BYTE;
      rx_toggle_o <= 1'b0;
    end else if (!chip_select_n_i && bit_count == BIT_LAST) begin
      rx_byte_o   <= next_byte;
      rx_toggle_o <= ~rx_toggle_o;
    end
  end

  // [R02] reply msb first
  // [R05] either idle polarity
  always_ff @(negedge serial_clk_i or posedge chip_select_n_i) begin
    if (chip_select_n_i) begin
      out_count <= BIT_FIRST;
      shift_out <= RESET_REPLY;
    end else if (!rose_seen) begin
      // Idle-high clock: the leading fall launches bit 7, so no shift yet
      shift_out <= shift_out;
    end else if (out_count == BIT_FIRST) begin
      shift_out <= {reply_byte_i[6:0], 1'b0};
      out_count <= out_count + 3'h1;
    end else begin
      shift_out <= {shift_out[6:0], 1'b0};
      out_count <= out_count + 3'h1;
    end
  end

  // First bit stands before the first falling edge
  assign reply_bit_o = (out_count == BIT_FIRST) ? reply_byte_i[7] : shift_out[7];
endmodule
`default_nettype wire

// File: testbench/cmd_port_props.sv
// Assertion checker for the host serial command port
`default_nettype none
module cmd_port_props
  import cmd_port_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        resetn_i,
  input wire logic        chip_select_n_i,
  input wire logic        reply_data_oe_o,
  input wire command_type command_o,
  input wire logic        command_valid_o,
  input wire logic        frame_active_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  sequence cs_idle_s;
    chip_select_n_i [*8];
  endsequence
  oe_release_a: assert property ($rose(chip_select_n_i) |-> ##[0:8] !reply_data_oe_o)
    else $error("reply line held after deselect");
  oe_idle_a: assert property (cs_idle_s |-> !reply_data_oe_o)
    else $error("reply line driven while idle");
  frame_sync_a: assert property ($fell(chip_select_n_i) |-> ##[1:6] frame_active_o)
    else $error("frame start not seen");
  valid_late_a: assert property (command_valid_o |-> chip_select_n_i && !frame_active_o)
    else $error("command ran inside frame");
  valid_pulse_a: assert property (command_valid_o |=> !command_valid_o)
    else $error("valid longer than one cycle");
  cmd_hold_a: assert property ($changed(command_o) |-> ##[0:1] command_valid_o)
    else $error("command changed without valid");
endmodule
`default_nettype wire

// File: testbench/host_master.sv
// Host model driving command frames and reading the reply line
`default_nettype none
module host_master (
  output logic     sclk_o,
  output logic     cs_n_o,
  output logic     data_o,
  input wire logic reply_i,
  input wire logic reply_oe_i
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    data_o = 1'b0;
  end
  task automatic send(input logic [15:0] cmd, input int nbits, input logic hi,
                      output logic [7:0] rx);
    // Clock settles at its idle level before select falls
    sclk_o = hi;
    #100;
    cs_n_o = 1'b0;
    #200;
    for (int i = 0; i < nbits; i++) begin
      data_o = cmd[15-i];
      sclk_o = 1'b0;
      #80;
      if (i < 8) rx[7-i] = reply_i & reply_oe_i;
      sclk_o = 1'b1;
      #80;
      if (i % 8 == 7) #160;
    end
    sclk_o = hi;
    #100;
    cs_n_o = 1'b1;
    // Released line flips so a stale bit never passes
    data_o = ~data_o;
  endtask
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the host serial command port
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import cmd_port_pkg::*;
  logic        clk_sys, resetn, sclk, cs_n, cmd_in, reply, reply_oe, valid, active;
  logic [7:0]  reply_byte;
  command_type command;
  int          n_errors = 0;
  int          n_compared = 0;
  host_master host (.sclk_o(sclk), .cs_n_o(cs_n), .data_o(cmd_in), .reply_i(reply),
                    .reply_oe_i(reply_oe));
  host_serial_command_port uut (.clk_sys_i(clk_sys), .resetn_i(resetn), .serial_clk_i(sclk),
    .chip_select_n_i(cs_n), .command_data_in_i(cmd_in), .reply_data_o(reply),
    .reply_data_oe_o(reply_oe), .reply_byte_i(reply_byte), .command_o(command),
    .command_valid_o(valid), .frame_active_o(active));
  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic frame(input logic [15:0] cmd, input int nbits, input logic hi,
                       input logic [7:0] rb);
    logic [7:0] rx;
    int n;
    reply_byte = rb;
    @(posedge clk_sys) #1;
    host.send(cmd, nbits, hi, rx);
    for (n = 0; n < 20 && valid !== 1'b1; n++) @(posedge clk_sys) #1;
    check(17'(n < 20), 17'(nbits >= 8));
    if (nbits >= 8) begin
      check(17'({command.byte0, command.two_bytes}), 17'({cmd[15:8], nbits > 8}));
      check(17'(rx), 17'(rb));
    end
    if (nbits > 8) check(17'(command.byte1), 17'(cmd[7:0]));
    repeat (12) @(posedge clk_sys);
    check(17'(reply_oe), 17'h0);
    #1200;
  endtask
  task automatic one_byte_low();
    frame(16'ha500, 8, 1'b0, 8'h3c);
  endtask
  task automatic two_bytes_high();
    frame(16'h817e, 16, 1'b1, 8'hc9);
  endtask
  task automatic partial_refused();
    frame(16'hff00, 5, 1'b0, 8'h5a);
  endtask
  task automatic summarize();
    $display("errors=%0d compared=%0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    resetn = 1'b0;
    reply_byte = 8'h00;
    repeat (20) @(posedge clk_sys);
    #1 resetn = 1'b1;
    repeat (5) @(posedge clk_sys);
    one_byte_low();
    two_bytes_high();
    partial_refused();
    summarize();
  end
endmodule
bind host_serial_command_port cmd_port_props props (.clk_sys_i(clk_sys_i),
  .resetn_i(resetn_i), .chip_select_n_i(chip_select_n_i), .reply_data_oe_o(reply_data_oe_o),
  .command_o(command_o), .command_valid_o(command_valid_o), .frame_active_o(frame_active_o));
`default_nettype wire
